// File: design/l1dc_top.sv
/*
  Two-way set associative write-back level-1 data cache with two CPU read ports,
  one CPU write port, explicit write-back, line fill from level2_memory and snoop writes.
  Assumes level2_memory accepts evicted words as they come and sends fill and snoop
  words in ascending word order.
*/
`timescale 1ns/1ns
`default_nettype none
module l1dc_top
  import l1dc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cpu_a_rd_req,
  input wire logic [ADDR_W-1:0] cpu_a_addr,
  output logic cpu_a_rd_valid,
  output logic [DATA_W-1:0] cpu_a_rd_data,
  input wire logic cpu_b_rd_req,
  input wire logic [ADDR_W-1:0] cpu_b_addr,
  output logic cpu_b_rd_valid,
  output logic [DATA_W-1:0] cpu_b_rd_data,
  input wire logic cpu_wr_req,
  input wire logic [ADDR_W-1:0] cpu_wr_addr,
  input wire logic [DATA_W-1:0] cpu_wr_data,
  output logic cpu_wr_done,
  output logic cpu_wr_miss,
  output logic busy,
  input wire logic wbk_req,
  input wire logic [ADDR_W-1:0] wbk_addr,
  output logic evict_valid,
  output logic [ADDR_W-1:0] evict_addr,
  output logic [DATA_W-1:0] evict_data,
  input wire logic [ADDR_W-1:0] l2_sram_base,
  output logic fill_req,
  output logic [ADDR_W-1:0] fill_addr,
  output logic fill_to_sram,
  input wire logic fill_valid,
  input wire logic [DATA_W-1:0] fill_data,
  output logic fill_ready,
  input wire logic snp_start,
  input wire logic [ADDR_W-1:0] snp_addr,
  input wire logic snp_wvalid,
  input wire logic [DATA_W-1:0] snp_wdata
);
  logic [1:0] rst_sync_ff;
  logic rst_sync_n;
  l1dc_ctl_t ctl_ff;
  l1dc_ctl_t nxt_ctl;
  l1dc_mem_if mif();
  logic [WAYS-1:0] hit_a_w;
  logic [WAYS-1:0] hit_b_w;
  logic [WAYS-1:0] hit_p_w;
  logic [WAYS-1:0] hit_k_w;
  logic [WAYS-1:0] hit_s_w;
  logic [WAYS-1:0] hit_wr_w;
  logic [ADDR_W-1:0] p_addr;
  logic [SET_W-1:0] p_set;
  logic alloc_now;
  logic victim;
  logic kill_snp;
  logic snp_we;

  function automatic logic [SET_W-1:0] set_of(input logic [ADDR_W-1:0] a);
    return a[SET_LSB +: SET_W];
  endfunction

  function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
    return a[TAG_LSB +: TAG_W];
  endfunction

  function automatic logic [OFF_W-1:0] word_of(input logic [ADDR_W-1:0] a);
    return a[WORD_LSB +: OFF_W];
  endfunction

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_ff[1];

  // tag compare for each lookup, one way per iteration; line index starts at 64-byte bit
  for (genvar gw = 0; gw < WAYS; gw++) begin : g_way
    assign hit_a_w[gw] = ctl_ff.valid[gw][set_of(cpu_a_addr)] && ctl_ff.tag[gw][set_of(cpu_a_addr)] == tag_of(cpu_a_addr);
    assign hit_b_w[gw] = ctl_ff.valid[gw][set_of(cpu_b_addr)] && ctl_ff.tag[gw][set_of(cpu_b_addr)] == tag_of(cpu_b_addr);
    assign hit_p_w[gw] = ctl_ff.valid[gw][set_of(p_addr)] && ctl_ff.tag[gw][set_of(p_addr)] == tag_of(p_addr);
    assign hit_k_w[gw] = ctl_ff.valid[gw][set_of(wbk_addr)] && ctl_ff.tag[gw][set_of(wbk_addr)] == tag_of(wbk_addr);
    assign hit_s_w[gw] = ctl_ff.valid[gw][set_of(snp_addr)] && ctl_ff.tag[gw][set_of(snp_addr)] == tag_of(snp_addr);
    assign hit_wr_w[gw] = ctl_ff.valid[gw][set_of(cpu_wr_addr)] && ctl_ff.tag[gw][set_of(cpu_wr_addr)] == tag_of(cpu_wr_addr);
  end

  // port a misses are served before port b misses
  assign p_addr = ctl_ff.miss_a ? ctl_ff.miss_a_addr : ctl_ff.miss_b_addr;
  assign p_set = set_of(p_addr);
  assign alloc_now = ctl_ff.state == L1DC_IDLE && (ctl_ff.miss_a || ctl_ff.miss_b) && !(|hit_p_w);
  assign victim = !ctl_ff.valid[0][p_set] ? 1'b0 : (!ctl_ff.valid[1][p_set] ? 1'b1 : ctl_ff.lru[p_set]);
  assign kill_snp = alloc_now && ctl_ff.snp_pend && ctl_ff.snp_set == p_set && ctl_ff.snp_way == victim;
  assign snp_we = snp_wvalid && ctl_ff.snp_pend && !kill_snp;

  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_ctl.rd_a_valid = 1'b0;
    nxt_ctl.rd_b_valid = 1'b0;
    nxt_ctl.evict_valid = 1'b0;
    mif.ra_addr = {hit_a_w[1], set_of(cpu_a_addr), word_of(cpu_a_addr)};
    mif.rb_addr = {hit_b_w[1], set_of(cpu_b_addr), word_of(cpu_b_addr)};
    mif.we = 1'b0;
    mif.wa = {hit_wr_w[1], set_of(cpu_wr_addr), word_of(cpu_wr_addr)};
    mif.wd = cpu_wr_data;
    cpu_wr_done = 1'b0;
    cpu_wr_miss = 1'b0;
    fill_ready = 1'b0;
    case (ctl_ff.state)
      L1DC_IDLE: begin
        if (ctl_ff.miss_a || ctl_ff.miss_b) begin
          if (ctl_ff.miss_a) begin
            nxt_ctl.miss_a = 1'b0;
          end else begin
            nxt_ctl.miss_b = 1'b0;
          end
          // a second miss to the same line finds it already filled and is dropped
          if (alloc_now) begin
            nxt_ctl.cur_set = p_set;
            nxt_ctl.cur_way = victim;
            nxt_ctl.cur_tag = tag_of(p_addr);
            nxt_ctl.wb_only = 1'b0;
            nxt_ctl.cnt = '0;
            nxt_ctl.valid[victim][p_set] = 1'b0;
            nxt_ctl.fill_addr = {tag_of(p_addr), p_set, {SET_LSB{1'b0}}};
            nxt_ctl.fill_sram = p_addr >= l2_sram_base;
            nxt_ctl.evict_addr = {ctl_ff.tag[victim][p_set], p_set, {SET_LSB{1'b0}}};
            if (ctl_ff.valid[victim][p_set] && ctl_ff.dirty[victim][p_set]) begin
              nxt_ctl.state = L1DC_EVICT;
            end else begin
              nxt_ctl.state = L1DC_FILL;
            end
          end
        end else if (wbk_req && (|hit_k_w) && ctl_ff.dirty[hit_k_w[1]][set_of(wbk_addr)]) begin
          nxt_ctl.cur_set = set_of(wbk_addr);
          nxt_ctl.cur_way = hit_k_w[1];
          nxt_ctl.wb_only = 1'b1;
          nxt_ctl.cnt = '0;
          nxt_ctl.dirty[hit_k_w[1]][set_of(wbk_addr)] = 1'b0;
          nxt_ctl.evict_addr = {tag_of(wbk_addr), set_of(wbk_addr), {SET_LSB{1'b0}}};
          nxt_ctl.state = L1DC_EVICT;
        end else begin
          if (cpu_a_rd_req) begin
            if (|hit_a_w) begin
              nxt_ctl.rd_a_valid = 1'b1;
              nxt_ctl.lru[set_of(cpu_a_addr)] = ~hit_a_w[1];
            end else begin
              nxt_ctl.miss_a = 1'b1;
              nxt_ctl.miss_a_addr = cpu_a_addr;
            end
          end
          if (cpu_b_rd_req) begin
            if (|hit_b_w) begin
              nxt_ctl.rd_b_valid = 1'b1;
              nxt_ctl.lru[set_of(cpu_b_addr)] = ~hit_b_w[1];
            end else begin
              nxt_ctl.miss_b = 1'b1;
              nxt_ctl.miss_b_addr = cpu_b_addr;
            end
          end
          if (cpu_wr_req) begin
            if (!(|hit_wr_w)) begin
              cpu_wr_miss = 1'b1;
            end else if (!snp_we) begin
              mif.we = 1'b1;
              cpu_wr_done = 1'b1;
              nxt_ctl.dirty[hit_wr_w[1]][set_of(cpu_wr_addr)] = 1'b1;
            end
          end
        end
      end
      L1DC_EVICT: begin
        mif.rb_addr = {ctl_ff.cur_way, ctl_ff.cur_set, ctl_ff.cnt[OFF_W-1:0]};
        if (ctl_ff.cnt != WORDS_CNT) begin
          nxt_ctl.evict_valid = 1'b1;
          nxt_ctl.evict_addr = {ctl_ff.evict_addr[ADDR_W-1:SET_LSB], ctl_ff.cnt[OFF_W-1:0], {WORD_LSB{1'b0}}};
          nxt_ctl.cnt = ctl_ff.cnt + CNT_ONE;
        end else begin
          nxt_ctl.cnt = '0;
          nxt_ctl.state = ctl_ff.wb_only ? L1DC_IDLE : L1DC_FILL;
        end
      end
      L1DC_FILL: begin
        // a snoop word owns the write port; the fill source waits every cycle that snp_we is high
        fill_ready = !snp_we;
        mif.wa = {ctl_ff.cur_way, ctl_ff.cur_set, ctl_ff.cnt[OFF_W-1:0]};
        mif.wd = fill_data;
        if (fill_valid && !snp_we) begin
          mif.we = 1'b1;
          nxt_ctl.cnt = ctl_ff.cnt + CNT_ONE;
          if (ctl_ff.cnt[OFF_W-1:0] == LAST_WORD) begin
            nxt_ctl.tag[ctl_ff.cur_way][ctl_ff.cur_set] = ctl_ff.cur_tag;
            nxt_ctl.valid[ctl_ff.cur_way][ctl_ff.cur_set] = 1'b1;
            nxt_ctl.dirty[ctl_ff.cur_way][ctl_ff.cur_set] = 1'b0;
            nxt_ctl.lru[ctl_ff.cur_set] = ~ctl_ff.cur_way;
            nxt_ctl.cnt = '0;
            nxt_ctl.state = L1DC_IDLE;
          end
        end
      end
      default: begin
        nxt_ctl.state = L1DC_IDLE;
      end
    endcase
    if (snp_we) begin
      mif.we = 1'b1;
      mif.wa = {ctl_ff.snp_way, ctl_ff.snp_set, ctl_ff.snp_cnt};
      mif.wd = snp_wdata;
      nxt_ctl.snp_cnt = ctl_ff.snp_cnt + OFF_ONE;
      if (ctl_ff.snp_cnt == LAST_WORD) begin
        nxt_ctl.snp_pend = 1'b0;
      end
    end
    if (kill_snp) begin
      nxt_ctl.snp_pend = 1'b0;
    end
    if (snp_start) begin
      // a line being displaced this cycle is no longer a snoop target
      nxt_ctl.snp_pend = (|hit_s_w) && !(alloc_now && p_set == set_of(snp_addr) && victim == hit_s_w[1]);
      nxt_ctl.snp_set = set_of(snp_addr);
      nxt_ctl.snp_way = hit_s_w[1];
      nxt_ctl.snp_cnt = '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctl_ff <= '0;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  l1dc_mem u_mem (
    .mclk(mclk),
    .m(mif)
  );

  assign busy = ctl_ff.state != L1DC_IDLE || ctl_ff.miss_a || ctl_ff.miss_b;
  assign cpu_a_rd_valid = ctl_ff.rd_a_valid;
  assign cpu_a_rd_data = mif.ra_data;
  assign cpu_b_rd_valid = ctl_ff.rd_b_valid;
  assign cpu_b_rd_data = mif.rb_data;
  assign evict_valid = ctl_ff.evict_valid;
  assign evict_addr = ctl_ff.evict_addr;
  assign evict_data = mif.rb_data;
  assign fill_req = ctl_ff.state == L1DC_FILL;
  assign fill_addr = ctl_ff.fill_addr;
  assign fill_to_sram = ctl_ff.fill_sram;
endmodule
`default_nettype wire

// File: shared/l1dc_pkg.sv
/*
  Constants and types of the two-way level-1 data cache with snoop write support.
  Assumes 32-bit byte addresses, 32-bit words and 64-byte lines.
*/
`default_nettype none
package l1dc_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int WAYS = 2;
  localparam int SETS = 16;
  localparam int SET_W = 4;
  localparam int LINE_BYTES = 64;
  localparam int OFF_W = 4;
  localparam int WORD_LSB = 2;
  localparam int SET_LSB = 6;
  localparam int TAG_LSB = 10;
  localparam int TAG_W = 22;
  localparam int MEM_AW = 9;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] WORDS_CNT = 5'h10;
  localparam logic [OFF_W-1:0] LAST_WORD = 4'hf;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [OFF_W-1:0] OFF_ONE = 4'h1;

  // gray along idle -> evict -> fill
  typedef enum logic [1:0] {
    L1DC_IDLE = 2'h0,
    L1DC_EVICT = 2'h1,
    L1DC_FILL = 2'h3
  } l1dc_state_t;

  typedef struct packed {
    l1dc_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [SET_W-1:0] cur_set;
    logic cur_way;
    logic [TAG_W-1:0] cur_tag;
    logic wb_only;
    logic miss_a;
    logic [ADDR_W-1:0] miss_a_addr;
    logic miss_b;
    logic [ADDR_W-1:0] miss_b_addr;
    logic [WAYS-1:0][SETS-1:0][TAG_W-1:0] tag;
    logic [WAYS-1:0][SETS-1:0] valid;
    logic [WAYS-1:0][SETS-1:0] dirty;
    logic [SETS-1:0] lru;
    logic snp_pend;
    logic [SET_W-1:0] snp_set;
    logic snp_way;
    logic [OFF_W-1:0] snp_cnt;
    logic rd_a_valid;
    logic rd_b_valid;
    logic evict_valid;
    logic [ADDR_W-1:0] evict_addr;
    logic [ADDR_W-1:0] fill_addr;
    logic fill_sram;
  } l1dc_ctl_t;
endpackage
`default_nettype wire

// File: shared/l1dc_mem_if.sv
/*
  Port bundle between the cache controller and its data array.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface l1dc_mem_if;
  import l1dc_pkg::*;
  logic [MEM_AW-1:0] ra_addr;
  logic [DATA_W-1:0] ra_data;
  logic [MEM_AW-1:0] rb_addr;
  logic [DATA_W-1:0] rb_data;
  logic we;
  logic [MEM_AW-1:0] wa;
  logic [DATA_W-1:0] wd;
  modport ctrl (output ra_addr, output rb_addr, output we, output wa, output wd, input ra_data, input rb_data);
  modport mem (input ra_addr, input rb_addr, input we, input wa, input wd, output ra_data, output rb_data);
endinterface
`default_nettype wire

// File: design/l1dc_mem.sv
/*
  Data array of the cache: two registered read ports and one write port.
  Assumes the controller never needs write-through on a same-cycle read; reads return old data.
*/
`timescale 1ns/1ns
`default_nettype none
module l1dc_mem
  import l1dc_pkg::*;
(
  input wire logic mclk,
  l1dc_mem_if.mem m
);
  logic [DATA_W-1:0] mem_ff [2**MEM_AW];
  logic [DATA_W-1:0] ra_ff;
  logic [DATA_W-1:0] rb_ff;

  always_ff @(posedge mclk) begin
    if (m.we) begin
      mem_ff[m.wa] <= m.wd;
    end
    ra_ff <= mem_ff[m.ra_addr];
    rb_ff <= mem_ff[m.rb_addr];
  end

  assign m.ra_data = ra_ff;
  assign m.rb_data = rb_ff;
endmodule
`default_nettype wire

// File: tb/l1dc_top_sva.sv
/*
  Port timing checker for l1dc_top.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module l1dc_top_sva
  import l1dc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cpu_a_rd_req,
  input wire logic cpu_a_rd_valid,
  input wire logic cpu_b_rd_req,
  input wire logic cpu_b_rd_valid,
  input wire logic busy,
  input wire logic cpu_wr_req,
  input wire logic cpu_wr_done,
  input wire logic cpu_wr_miss,
  input wire logic evict_valid,
  input wire logic [ADDR_W-1:0] evict_addr,
  input wire logic fill_req,
  input wire logic [ADDR_W-1:0] fill_addr,
  input wire logic fill_to_sram,
  input wire logic [ADDR_W-1:0] l2_sram_base
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  rd_a_taken_a: assert property (cpu_a_rd_valid |-> $past(cpu_a_rd_req) && !$past(busy))
    else $error("port a answered without a taken request");
  rd_b_taken_a: assert property (cpu_b_rd_valid |-> $past(cpu_b_rd_req) && !$past(busy))
    else $error("port b answered without a taken request");
  evict_burst_a: assert property ($rose(evict_valid) |-> evict_valid[*8] ##1 evict_valid[*8] ##1 !evict_valid)
    else $error("evicted line is not sixteen words");
  evict_step_a: assert property (evict_valid && $past(evict_valid) |-> evict_addr == $past(evict_addr) + 32'h0000_0004)
    else $error("evicted words not ascending");
  evict_head_a: assert property ($rose(evict_valid) |-> evict_addr[5:0] == 6'h00 && $past(busy))
    else $error("eviction starts off a line boundary");
  fill_align_a: assert property (fill_req |-> fill_addr[5:0] == 6'h00 && busy)
    else $error("fill address not line aligned");
  fill_region_a: assert property (fill_req |-> fill_to_sram == (fill_addr >= l2_sram_base))
    else $error("fill region flag wrong");
  fill_busy_a: assert property ($fell(busy) |-> !fill_req && !evict_valid)
    else $error("busy fell while a line moves");
  wr_answer_a: assert property (cpu_wr_done || cpu_wr_miss |-> cpu_wr_req && !busy && !(cpu_wr_done && cpu_wr_miss))
    else $error("write answer without a taken request");
endmodule
`default_nettype wire

// File: tb/l1dc_l2_model.sv
/*
  Level-2 side model that answers line fills one word per accepted beat.
  Assumes fill_req holds until the last word of the line is taken.
*/
`timescale 1ns/1ns
`default_nettype none
module l1dc_l2_model
  import l1dc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic fill_req,
  input wire logic [ADDR_W-1:0] fill_addr,
  input wire logic fill_ready,
  output logic fill_valid,
  output logic [DATA_W-1:0] fill_data
);
  logic [OFF_W-1:0] cnt;
  logic [DATA_W-1:0] junk;
  // sram and cache regions answer alike; only the cache tells them apart
  assign fill_data = fill_valid ? ~(fill_addr + {cnt, 2'b00}) : junk;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fill_valid <= 1'b0;
      cnt <= '0;
      junk <= 32'h5a5a_a5a5;
    end else begin
      junk <= ~junk;
      if (fill_valid && fill_ready) cnt <= cnt + OFF_ONE;
      // a stalled word is held until taken, never withdrawn
      if (!fill_valid || fill_ready) begin
        fill_valid <= fill_req && !(fill_valid && cnt == LAST_WORD) && (!slow || $urandom_range(1) == 1);
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/l1d_snoop_coherence_test.sv
/*
  Self-checking bench for l1dc_top with a level-2 fill model.
  Assumes the checker is bound from this file.
*/
`timescale 1ns/1ns
`default_nettype none
module l1d_snoop_coherence_test;
  import l1dc_pkg::*;
  localparam logic [ADDR_W-1:0] AX = 32'h0001_0040, AY = 32'h0000_2040, AZ = 32'h0000_4040, AW = 32'h0000_0080;
  localparam logic [ADDR_W-1:0] AV = 32'h0000_00c0, AU = 32'h0000_0300, AT = 32'h0001_0100, AS = 32'h0000_0140;
  logic mclk = 1'b0, rst_n = 1'b0, cpu_a_rd_req = 1'b0, cpu_b_rd_req = 1'b0, cpu_wr_req = 1'b0, wbk_req = 1'b0;
  logic snp_start = 1'b0, snp_wvalid = 1'b0, slow = 1'b0, miss;
  logic [ADDR_W-1:0] cpu_a_addr = '0, cpu_b_addr = '0, cpu_wr_addr = '0, wbk_addr = '0, snp_addr = '0;
  logic [ADDR_W-1:0] l2_sram_base = 32'h0001_0000, evict_addr, fill_addr;
  logic [DATA_W-1:0] cpu_wr_data = '0, snp_wdata = '0, cpu_a_rd_data, cpu_b_rd_data, evict_data, fill_data, sd, dw;
  logic cpu_a_rd_valid, cpu_b_rd_valid, cpu_wr_done, cpu_wr_miss, busy, evict_valid, fill_req, fill_to_sram;
  logic fill_valid, fill_ready;
  logic [DATA_W-1:0] qa[$], qb[$];
  logic [63:0] qe[$];
  int bad_count = 0, check_count = 0;
  always #20 mclk = ~mclk;
  l1dc_top i_l1dc_top(.mclk, .rst_n, .cpu_a_rd_req, .cpu_a_addr, .cpu_a_rd_valid, .cpu_a_rd_data, .cpu_b_rd_req,
    .cpu_b_addr, .cpu_b_rd_valid, .cpu_b_rd_data, .cpu_wr_req, .cpu_wr_addr, .cpu_wr_data, .cpu_wr_done, .cpu_wr_miss,
    .busy, .wbk_req, .wbk_addr, .evict_valid, .evict_addr, .evict_data, .l2_sram_base, .fill_req, .fill_addr,
    .fill_to_sram, .fill_valid, .fill_data, .fill_ready, .snp_start, .snp_addr, .snp_wvalid, .snp_wdata);
  l1dc_l2_model i_l1dc_l2_model(.mclk, .rst_n, .slow, .fill_req, .fill_addr, .fill_ready, .fill_valid, .fill_data);
  function automatic logic [DATA_W-1:0] mem(input logic [ADDR_W-1:0] a);
    return ~{a[31:2], 2'b00};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string n, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // answers are registered, so they are looked at mid-cycle while they stand
  always @(negedge mclk) begin
    if (cpu_a_rd_valid === 1'b1) check("rd_a", qa.size() ? qa.pop_front() : 'x, cpu_a_rd_data);
    if (cpu_b_rd_valid === 1'b1) check("rd_b", qb.size() ? qb.pop_front() : 'x, cpu_b_rd_data);
    if (evict_valid === 1'b1) check("evict", qe.size() ? qe.pop_front() : 'x, {evict_addr, evict_data});
  end
  task automatic wait_idle;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge mclk);
    if (busy !== 1'b0) begin
      check("busy", 0, busy);
      report_and_stop;
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] aa, ab, input logic [DATA_W-1:0] da, db);
    cpu_a_rd_req = 1'b1;
    cpu_b_rd_req = 1'b1;
    cpu_a_addr = aa;
    cpu_b_addr = ab;
    qa.push_back(da);
    qb.push_back(db);
    @(negedge mclk);
    cpu_a_rd_req = 1'b0;
    cpu_b_rd_req = 1'b0;
    miss = busy === 1'b1;
    // a miss gives no answer, so its note is withdrawn
    if (miss) void'(qa.pop_back());
    if (miss) void'(qb.pop_back());
  endtask
  // both ports miss or both hit; a mixed pair would leave the answer count open
  task automatic rdh(input logic [ADDR_W-1:0] aa, ab, input logic [DATA_W-1:0] da, db);
    rd(aa, ab, da, db);
    if (miss) begin
      wait_idle;
      rd(aa, ab, da, db);
      check("retry_hit", 0, miss);
    end
    @(negedge mclk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic hit);
    cpu_wr_req = 1'b1;
    cpu_wr_addr = a;
    cpu_wr_data = dw;
    #1;
    check("wr_done", hit, cpu_wr_done);
    check("wr_miss", !hit, cpu_wr_miss);
    @(negedge mclk);
    cpu_wr_req = 1'b0;
    @(negedge mclk);
  endtask
  task automatic wbk(input logic [ADDR_W-1:0] a);
    wbk_req = 1'b1;
    wbk_addr = a;
    @(negedge mclk);
    wbk_req = 1'b0;
    @(negedge mclk);
    wait_idle;
  endtask
  task automatic snp(input logic [ADDR_W-1:0] a, input logic st, input int n, input int i0);
    snp_addr = a;
    snp_start = st;
    if (st) @(negedge mclk);
    snp_start = 1'b0;
    for (int i = i0; i < i0 + n; i++) begin
      snp_wvalid = 1'b1;
      snp_wdata = sd ^ i;
      @(negedge mclk);
    end
    snp_wvalid = 1'b0;
    snp_wdata = ~snp_wdata;
  endtask
  initial begin
    void'($urandom(64));
    sd = $urandom;
    dw = $urandom;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    rdh(AX, AW, mem(AX), mem(AW));
    rdh(AY + 4, AV, mem(AY + 4), mem(AV));
    rdh(AX + 8, AY + 60, mem(AX + 8), mem(AY + 60));
    snp(AX, 1'b1, 16, 0);
    rdh(AX + 8, AX + 60, sd ^ 2, sd ^ 15);
    wr(AX + 4, 1'b1);
    wr(AU, 1'b0);
    for (int i = 0; i < 16; i++) qe.push_back({AX + 4 * i, i == 1 ? dw : sd ^ i});
    wbk(AX);
    wbk(AX);
    wbk(AY);
    slow = 1'b1;
    snp(AU, 1'b1, 16, 0);
    rdh(AU, AS, mem(AU), mem(AS));
    rdh(AY, AV, mem(AY), mem(AV));
    snp(AX, 1'b1, 2, 0);
    // dirty the snooped line so its replacement goes through eviction
    wr(AX + 8, 1'b1);
    for (int i = 0; i < 16; i++) qe.push_back({AX + 4 * i, i == 2 ? dw : sd ^ i});
    rd(AZ, AT, mem(AZ), mem(AT));
    check("victim_miss", 1, miss);
    snp(AX, 1'b0, 14, 2);
    wait_idle;
    rdh(AZ + 60, AZ + 4, mem(AZ + 60), mem(AZ + 4));
    repeat (3) @(negedge mclk);
    check("left", 0, qa.size() + qb.size() + qe.size());
    report_and_stop;
  end
endmodule
bind l1dc_top l1dc_top_sva i_l1dc_top_sva(.mclk, .rst_n, .cpu_a_rd_req, .cpu_a_rd_valid, .cpu_b_rd_req,
  .cpu_b_rd_valid, .busy, .cpu_wr_req, .cpu_wr_done, .cpu_wr_miss, .evict_valid, .evict_addr, .fill_req, .fill_addr,
  .fill_to_sram, .l2_sram_base);
`default_nettype wire
